// File: pkg/clock_modes_regs.svh
// register offsets, field positions, reset values and counts of the clock block
// assumes a 32-bit AHB-Lite slave decoding byte addresses haddr[7:0]
`ifndef CLOCK_MODES_REGS_SVH
`define CLOCK_MODES_REGS_SVH

// --------------------------------------------------------------------------
// offsets
// --------------------------------------------------------------------------
`define SYS_CTRL_OFS        8'h00
`define FAST_RC_CTRL_OFS    8'h04
`define EXT_FAST_CTRL_OFS   8'h08
`define SLOW_XTAL_CTRL_OFS  8'h0C
`define MODE_STAT_OFS       8'h10

// --------------------------------------------------------------------------
// fields
// --------------------------------------------------------------------------
`define SEL_MSB             7
`define SEL_LSB             5
`define FAST_SRC_BIT        3
`define SLOW_SRC_BIT        2
`define FAST_KEEP_BIT       1
`define SLOW_KEEP_BIT       0
`define RC_FREQ_MSB         3
`define RC_FREQ_LSB         2
`define RC_EN_BIT           0
`define EXT_FAST_EN_BIT     0
`define XT_SPEEDUP_BIT      2
`define XT_READY_BIT        1
`define XT_EN_BIT           0
`define SUB_SEL_CODE        3'h7
`define RC_FREQ_8M_ALT      2'h3
`define RC_FREQ_8M          2'h0

// --------------------------------------------------------------------------
// reset values
// --------------------------------------------------------------------------
`define SYS_CTRL_RST        8'h00
`define FAST_RC_CTRL_RST    8'h01
`define EXT_FAST_CTRL_RST   8'h00
`define SLOW_XTAL_CTRL_RST  8'h00

// --------------------------------------------------------------------------
// timing, start-up counted in slow crystal periods
// --------------------------------------------------------------------------
`define CLOCK_PERIOD_NS          50
`define SLOW_XTAL_START_SPEEDUP  16'h0400
`define SLOW_XTAL_START_LOWPWR   16'h4000

`endif

// File: pkg/clock_modes_pkg.sv
// types shared by the clock and power mode block
// assumes nothing beyond a SystemVerilog compiler
package clock_modes_pkg;

	// gray codes along fast -> slow -> idle chain
	typedef enum logic [2:0] {
		MODE_FAST      = 3'h0,
		MODE_SLOW      = 3'h1,
		IDLE_SLOW_ONLY = 3'h3,
		IDLE_BOTH_OSC  = 3'h2,
		IDLE_FAST_ONLY = 3'h6,
		MODE_SLEEP     = 3'h7
	} op_mode_type;

	typedef logic [2:0] sysclk_sel_type;

endpackage

// File: pkg/clock_div_if.sv
// carries fast clock ticks and the selection to the divider, divided tick back
// assumes both ends run on the same clock
interface clock_div_if;
	import clock_modes_pkg::*;
	logic           fastTick;
	sysclk_sel_type sel;
	logic           divTick;

	modport owner   (output fastTick, output sel, input divTick);
	modport divider (input fastTick, input sel, output divTick);
endinterface

// File: rtl/fast_clock_divider.sv
// power-of-two divider of the fast clock tick, one tick per 2^sel fast ticks
// assumes fastTick is a one-cycle pulse on clock; divTick comes from a flop
`include "clock_modes_regs.svh"

module fast_clock_divider (
	input wire logic        clock,
	input wire logic        rstn,
	clock_div_if.divider    port
);
	import clock_modes_pkg::*;

	logic [5:0] count;
	logic [5:0] mask;

	// --------------------------------------------------------------------------
	// divider chain
	// --------------------------------------------------------------------------
	always_comb begin
		mask = 6'((7'h01 << port.sel) - 7'h01);
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			count <= 6'h00;
		end else if (port.fastTick) begin
			count <= count + 6'h01;
		end
	end

	// code 7 is the sub clock, never a divided tick
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			port.divTick <= 1'b0;
		end else begin
			port.divTick <= port.fastTick && (port.sel != `SUB_SEL_CODE)
				&& ((count & mask) == mask); // [R05] [R13]
		end
	end

	divTick_cause_a: assert property (@(posedge clock) disable iff (!rstn) // [R05]
		port.divTick |-> $past(port.fastTick) && $past(port.sel) != `SUB_SEL_CODE)
		else $error("divided tick without a fast tick");

	divTick_rate_a: assert property (@(posedge clock) disable iff (!rstn) // [R13]
		port.fastTick && port.sel == 3'h1 && count[0] == 1'b0 |=> !port.divTick)
		else $error("half rate tick on even count");

endmodule

// File: rtl/system_clock_and_power_modes.sv
// clock source selection and operating mode control behind an AHB-Lite slave
// assumes oscillator waveforms arrive asynchronously and are much slower than clock;
// halt and wake pulses come from the core on clock
`include "clock_modes_regs.svh"

// How it works
// R01 - fast RC runs at 8, 12 or 16 MHz
// R02 - fast clock from fast crystal or fast RC
// R03 - sub clock from slow crystal or slow RC
// R04 - system clock selection changeable at any time
// R05 - divided choices are fast clock /2 to /64
// R06 - speed-up bit picks fast start or low power
// R07 - low-power slow crystal keeps running normally
// R08 - slow crystal mode locked while it drives system
// R09 - slow crystal usable only after start-up delay
// R10 - slow mode: fast oscillator follows its enable
// R11 - six modes, two running, four halted
// R12 - slow crystal pins free when crystal unused
// R13 - codes 0-6 divide by 1..64, 7 is sub
// R14 - halt, both keeps clear: sleep
// R15 - halt, slow keep only: slow-only idle
// R16 - halt, both keeps set: both oscillators idle
// R17 - halt, fast keep only: fast-only idle
// R18 - slow RC always on except sleep without watchdog
module system_clock_and_power_modes #(
	parameter int unsigned START_SPEEDUP = `SLOW_XTAL_START_SPEEDUP,
	parameter int unsigned START_LOWPWR  = `SLOW_XTAL_START_LOWPWR
) (
	input  wire logic                    clock,
	input  wire logic                    rstn,
	input  wire logic                    hsel,
	input  wire logic [31:0]             haddr,
	input  wire logic [1:0]              htrans,
	input  wire logic                    hwrite,
	input  wire logic [2:0]              hsize,
	input  wire logic [31:0]             hwdata,
	input  wire logic                    hready,
	output logic                         hreadyout,
	output logic                         hresp,
	output logic [31:0]                  hrdata,
	input  wire logic                    extFastCrystalClk,
	input  wire logic                    intFastRcClk,
	input  wire logic                    extSlowCrystalClk,
	input  wire logic                    intSlowRcClk,
	input  wire logic                    haltReq,
	input  wire logic                    wakeReq,
	input  wire logic                    watchdogEn,
	output logic                         sysClkTick,
	output logic                         coreRun,
	output clock_modes_pkg::op_mode_type opMode,
	output logic                         fastClkOn,
	output logic                         subClkOn,
	output logic                         extFastCrystalRun,
	output logic                         intFastRcRun,
	output logic [1:0]                   fastRcFreqCode,
	output logic                         extSlowCrystalRun,
	output logic                         slowXtalSpeedupOut,
	output logic                         slowXtalReady,
	output logic                         intSlowRcRun,
	output logic                         slowXtalPinsFree
);
	import clock_modes_pkg::*;

	// --------------------------------------------------------------------------
	// control fields
	// --------------------------------------------------------------------------
	sysclk_sel_type sysclkSel;
	logic           fastSrcSel;
	logic           slowSrcSel;
	logic           fastOscHaltKeep;
	logic           slowOscHaltKeep;
	logic [1:0]     fastRcFreqSel;
	logic           intFastRcEn;
	logic           extFastCrystalEn;
	logic           slowXtalSpeedup;
	logic           slowXtalEn;
	logic           slowLocked;

	// --------------------------------------------------------------------------
	// AHB-Lite slave, zero wait states
	// --------------------------------------------------------------------------
	logic       wrPend;
	logic [7:0] wrAddr;
	logic       addrPhase;
	logic [7:0] wdata;

	assign addrPhase = hsel && hready && htrans[1];
	assign wdata     = hwdata[7:0];
	assign slowLocked = (sysclkSel == `SUB_SEL_CODE) && slowSrcSel;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
		end else begin
			wrPend <= addrPhase && hwrite;
			wrAddr <= haddr[7:0];
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sysclkSel        <= 3'(`SYS_CTRL_RST >> `SEL_LSB);
			fastSrcSel       <= 1'(`SYS_CTRL_RST >> `FAST_SRC_BIT);
			slowSrcSel       <= 1'(`SYS_CTRL_RST >> `SLOW_SRC_BIT);
			fastOscHaltKeep  <= 1'(`SYS_CTRL_RST >> `FAST_KEEP_BIT);
			slowOscHaltKeep  <= 1'(`SYS_CTRL_RST >> `SLOW_KEEP_BIT);
			fastRcFreqSel    <= 2'(`FAST_RC_CTRL_RST >> `RC_FREQ_LSB);
			intFastRcEn      <= 1'(`FAST_RC_CTRL_RST >> `RC_EN_BIT);
			extFastCrystalEn <= 1'(`EXT_FAST_CTRL_RST >> `EXT_FAST_EN_BIT);
			slowXtalSpeedup  <= 1'(`SLOW_XTAL_CTRL_RST >> `XT_SPEEDUP_BIT);
			slowXtalEn       <= 1'(`SLOW_XTAL_CTRL_RST >> `XT_EN_BIT);
		end else if (wrPend) begin
			case (wrAddr)
				`SYS_CTRL_OFS: begin
					sysclkSel       <= wdata[`SEL_MSB:`SEL_LSB]; // [R04]
					fastSrcSel      <= wdata[`FAST_SRC_BIT];
					slowSrcSel      <= wdata[`SLOW_SRC_BIT];
					fastOscHaltKeep <= wdata[`FAST_KEEP_BIT];
					slowOscHaltKeep <= wdata[`SLOW_KEEP_BIT];
				end
				`FAST_RC_CTRL_OFS: begin
					fastRcFreqSel <= wdata[`RC_FREQ_MSB:`RC_FREQ_LSB];
					intFastRcEn   <= wdata[`RC_EN_BIT];
				end
				`EXT_FAST_CTRL_OFS: begin
					extFastCrystalEn <= wdata[`EXT_FAST_EN_BIT];
				end
				`SLOW_XTAL_CTRL_OFS: begin
					// mode held while the crystal drives the system
					if (!slowLocked) begin
						slowXtalSpeedup <= wdata[`XT_SPEEDUP_BIT]; // [R08]
					end
					slowXtalEn <= wdata[`XT_EN_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// read data captured in the address phase, unmapped reads zero
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			case (haddr[7:0])
				`SYS_CTRL_OFS:       hrdata <= {24'h000000, sysclkSel, 1'b0, fastSrcSel,
					slowSrcSel, fastOscHaltKeep, slowOscHaltKeep};
				`FAST_RC_CTRL_OFS:   hrdata <= {28'h0000000, fastRcFreqSel, 1'b0, intFastRcEn};
				`EXT_FAST_CTRL_OFS:  hrdata <= {31'h00000000, extFastCrystalEn};
				`SLOW_XTAL_CTRL_OFS: hrdata <= {29'h00000000, slowXtalSpeedup,
					slowXtalReady, slowXtalEn};
				`MODE_STAT_OFS:      hrdata <= {26'h0000000, opMode, subClkOn,
					fastClkOn, coreRun};
				default:             hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// --------------------------------------------------------------------------
	// oscillator edge capture
	// --------------------------------------------------------------------------
	logic [3:0] oscMeta;
	logic [3:0] oscSync;
	logic [3:0] oscLast;
	logic [3:0] oscRise;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			oscMeta <= 4'h0;
			oscSync <= 4'h0;
			oscLast <= 4'h0;
		end else begin
			oscMeta <= {intSlowRcClk, extSlowCrystalClk, intFastRcClk, extFastCrystalClk};
			oscSync <= oscMeta;
			oscLast <= oscSync;
		end
	end

	assign oscRise = oscSync & ~oscLast;

	// --------------------------------------------------------------------------
	// fast and sub clock ticks
	// --------------------------------------------------------------------------
	clock_div_if div ();
	logic fastTick;
	logic subTick;

	always_comb begin
		fastTick = fastClkOn && (fastSrcSel ? oscRise[0] : oscRise[1]); // [R02]
		subTick  = subClkOn && (slowSrcSel ? (oscRise[2] && slowXtalReady)
			: oscRise[3]); // [R03]
		div.fastTick = fastTick;
		div.sel      = sysclkSel;
	end

	fast_clock_divider divider (
		.clock (clock),
		.rstn  (rstn),
		.port  (div)
	);

	// --------------------------------------------------------------------------
	// operating mode
	// --------------------------------------------------------------------------
	op_mode_type modeNext;
	op_mode_type runMode;
	op_mode_type haltMode;

	always_comb begin
		runMode  = (sysclkSel == `SUB_SEL_CODE) ? MODE_SLOW : MODE_FAST; // [R13]
		case ({fastOscHaltKeep, slowOscHaltKeep})
			2'b00:   haltMode = MODE_SLEEP;     // [R14]
			2'b01:   haltMode = IDLE_SLOW_ONLY; // [R15]
			2'b11:   haltMode = IDLE_BOTH_OSC;  // [R16]
			default: haltMode = IDLE_FAST_ONLY; // [R17]
		endcase
		case (opMode)
			MODE_FAST, MODE_SLOW: modeNext = haltReq ? haltMode : runMode; // [R11]
			IDLE_SLOW_ONLY, IDLE_BOTH_OSC, IDLE_FAST_ONLY, MODE_SLEEP:
				modeNext = wakeReq ? runMode : opMode;
			default:              modeNext = MODE_FAST;
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			opMode  <= MODE_FAST;
			coreRun <= 1'b1;
		end else begin
			opMode  <= modeNext;
			coreRun <= (modeNext == MODE_FAST) || (modeNext == MODE_SLOW);
		end
	end

	// --------------------------------------------------------------------------
	// oscillator enables, all decided from the next mode
	// --------------------------------------------------------------------------
	logic fastOnNext;
	logic subOnNext;
	logic sysOnNext;

	always_comb begin
		case (modeNext)
			MODE_FAST: begin
				fastOnNext = 1'b1;
				subOnNext  = 1'b1;
				sysOnNext  = 1'b1;
			end
			MODE_SLOW: begin
				// fast side may stay up for peripherals
				fastOnNext = fastSrcSel ? extFastCrystalEn : intFastRcEn; // [R10]
				subOnNext  = 1'b1;
				sysOnNext  = 1'b1;
			end
			IDLE_SLOW_ONLY: begin
				fastOnNext = 1'b0;
				subOnNext  = 1'b1;
				sysOnNext  = (sysclkSel == `SUB_SEL_CODE); // [R15]
			end
			IDLE_BOTH_OSC: begin
				fastOnNext = 1'b1;
				subOnNext  = 1'b1;
				sysOnNext  = 1'b1; // [R16]
			end
			IDLE_FAST_ONLY: begin
				fastOnNext = 1'b1;
				subOnNext  = 1'b0;
				sysOnNext  = (sysclkSel != `SUB_SEL_CODE); // [R17]
			end
			default: begin
				fastOnNext = 1'b0;
				subOnNext  = 1'b0;
				sysOnNext  = 1'b0; // [R14]
			end
		endcase
	end

	logic sysOn;

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fastClkOn         <= 1'b1;
			subClkOn          <= 1'b1;
			sysOn             <= 1'b1;
			extFastCrystalRun <= 1'b0;
			intFastRcRun      <= 1'b1;
			extSlowCrystalRun <= 1'b0;
			intSlowRcRun      <= 1'b1;
		end else begin
			fastClkOn         <= fastOnNext;
			subClkOn          <= subOnNext;
			sysOn             <= sysOnNext;
			extFastCrystalRun <= fastOnNext && fastSrcSel;
			intFastRcRun      <= fastOnNext && !fastSrcSel;
			extSlowCrystalRun <= slowXtalEn && subOnNext; // [R09]
			intSlowRcRun      <= (modeNext != MODE_SLEEP) || watchdogEn; // [R18]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sysClkTick <= 1'b0;
		end else begin
			sysClkTick <= sysOn && ((sysclkSel == `SUB_SEL_CODE) ? subTick
				: div.divTick); // [R04] [R05]
		end
	end

	// --------------------------------------------------------------------------
	// analog controls and slow crystal start-up
	// --------------------------------------------------------------------------
	logic [15:0] startCount;
	logic [15:0] startTarget;

	// clearing speed-up after start keeps the crystal running
	assign startTarget = slowXtalSpeedup ? 16'(START_SPEEDUP) : 16'(START_LOWPWR); // [R06] [R07]

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			startCount    <= 16'h0000;
			slowXtalReady <= 1'b0;
		end else if (!extSlowCrystalRun) begin
			startCount    <= 16'h0000;
			slowXtalReady <= 1'b0;
		end else if (oscRise[2] && !slowXtalReady) begin
			startCount    <= startCount + 16'h0001;
			slowXtalReady <= (startCount + 16'h0001) >= startTarget; // [R09]
		end
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fastRcFreqCode     <= `RC_FREQ_8M;
			slowXtalSpeedupOut <= 1'b0;
			slowXtalPinsFree   <= 1'b1;
		end else begin
			fastRcFreqCode     <= (fastRcFreqSel == `RC_FREQ_8M_ALT) ? `RC_FREQ_8M
				: fastRcFreqSel; // [R01]
			slowXtalSpeedupOut <= slowXtalSpeedup; // [R06]
			slowXtalPinsFree   <= !slowXtalEn && !slowSrcSel; // [R12]
		end
	end

	// --------------------------------------------------------------------------
	// checks
	// --------------------------------------------------------------------------
	rcFreq_map_a: assert property (@(posedge clock) disable iff (!rstn) // [R01]
		1 |=> fastRcFreqCode == (($past(fastRcFreqSel) == 2'h3) ? 2'h0 : $past(fastRcFreqSel)))
		else $error("fast RC frequency code wrong");

	speedup_lock_a: assert property (@(posedge clock) disable iff (!rstn) // [R08]
		slowLocked |=> $stable(slowXtalSpeedup))
		else $error("slow crystal mode changed while locked");

	sleep_entry_a: assert property (@(posedge clock) disable iff (!rstn) // [R14]
		coreRun && haltReq && !fastOscHaltKeep && !slowOscHaltKeep
		|=> opMode == MODE_SLEEP && !coreRun && !subClkOn && !fastClkOn)
		else $error("sleep not entered");

	idle_slow_a: assert property (@(posedge clock) disable iff (!rstn) // [R15]
		coreRun && haltReq && !fastOscHaltKeep && slowOscHaltKeep
		|=> opMode == IDLE_SLOW_ONLY && subClkOn && !fastClkOn)
		else $error("slow-only idle not entered");

	idle_both_a: assert property (@(posedge clock) disable iff (!rstn) // [R16]
		coreRun && haltReq && fastOscHaltKeep && slowOscHaltKeep
		|=> opMode == IDLE_BOTH_OSC && subClkOn && fastClkOn && !coreRun)
		else $error("both-oscillator idle not entered");

	idle_fast_a: assert property (@(posedge clock) disable iff (!rstn) // [R17]
		coreRun && haltReq && fastOscHaltKeep && !slowOscHaltKeep
		|=> opMode == IDLE_FAST_ONLY && !subClkOn && fastClkOn)
		else $error("fast-only idle not entered");

	slowRc_on_a: assert property (@(posedge clock) disable iff (!rstn) // [R18]
		opMode != MODE_SLEEP || watchdogEn |-> intSlowRcRun)
		else $error("slow RC stopped outside sleep");

	slow_start_a: assert property (@(posedge clock) disable iff (!rstn) // [R09]
		$rose(extSlowCrystalRun) |-> !slowXtalReady [*3])
		else $error("slow crystal ready without start-up");

	slow_fastoff_a: assert property (@(posedge clock) disable iff (!rstn) // [R10]
		opMode == MODE_SLOW
		|-> fastClkOn == ($past(fastSrcSel) ? $past(extFastCrystalEn) : $past(intFastRcEn)))
		else $error("fast oscillator not following its enable in slow mode");

	pins_free_a: assert property (@(posedge clock) disable iff (!rstn) // [R12]
		slowXtalEn |=> !slowXtalPinsFree)
		else $error("crystal pins freed while crystal enabled");

endmodule

// File: verif/system_clock_and_power_modes_tb.sv
// self-checking bench of the clock source and operating mode block
// assumes the shared header and package are compiled first; one clock domain
`include "clock_modes_regs.svh"

module system_clock_and_power_modes_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import clock_modes_pkg::*;

	localparam int FAST_RC_PER  = 6;
	localparam int EXT_FAST_PER = 8;
	localparam int SLOW_XT_PER  = 12;
	localparam int SLOW_RC_PER  = 16;

	logic        clock              = 1'b0;
	logic        rstn               = 1'b0;
	logic [31:0] haddr              = 32'h0;
	logic [1:0]  htrans             = 2'h0;
	logic        hwrite             = 1'b0;
	logic [31:0] hwdata             = 32'h0;
	logic        extFastCrystalClk  = 1'b0;
	logic        intFastRcClk       = 1'b0;
	logic        extSlowCrystalClk  = 1'b0;
	logic        intSlowRcClk       = 1'b0;
	logic        haltReq            = 1'b0;
	logic        wakeReq            = 1'b0;
	logic        watchdogEn         = 1'b0;
	logic        hready;
	logic        hresp;
	logic [31:0] hrdata;
	logic        sysClkTick;
	logic        coreRun;
	op_mode_type opMode;
	logic        fastClkOn;
	logic        subClkOn;
	logic        extFastCrystalRun;
	logic        intFastRcRun;
	logic [1:0]  fastRcFreqCode;
	logic        extSlowCrystalRun;
	logic        slowXtalSpeedupOut;
	logic        slowXtalReady;
	logic        intSlowRcRun;
	logic        slowXtalPinsFree;
	int          fail_count         = 0;
	int          n_checks           = 0;
	int          seed               = 46;
	int          n;
	logic [31:0] q;

	system_clock_and_power_modes #(.START_SPEEDUP(4), .START_LOWPWR(8)) dut (
		.clock(clock), .rstn(rstn), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.extFastCrystalClk(extFastCrystalClk), .intFastRcClk(intFastRcClk),
		.extSlowCrystalClk(extSlowCrystalClk), .intSlowRcClk(intSlowRcClk),
		.haltReq(haltReq), .wakeReq(wakeReq), .watchdogEn(watchdogEn),
		.sysClkTick(sysClkTick), .coreRun(coreRun), .opMode(opMode),
		.fastClkOn(fastClkOn), .subClkOn(subClkOn), .extFastCrystalRun(extFastCrystalRun),
		.intFastRcRun(intFastRcRun), .fastRcFreqCode(fastRcFreqCode),
		.extSlowCrystalRun(extSlowCrystalRun), .slowXtalSpeedupOut(slowXtalSpeedupOut),
		.slowXtalReady(slowXtalReady), .intSlowRcRun(intSlowRcRun),
		.slowXtalPinsFree(slowXtalPinsFree)
	);

	// ----------------------------------------------------------------------
	// clocks
	// ----------------------------------------------------------------------
	initial forever #25 clock = ~clock;
	// oscillators offset from clock so the synchronisers never see a tie
	initial begin #10; forever #(FAST_RC_PER * 25) intFastRcClk = ~intFastRcClk; end
	initial begin #12; forever #(EXT_FAST_PER * 25) extFastCrystalClk = ~extFastCrystalClk; end
	initial begin #14; forever #(SLOW_XT_PER * 25) extSlowCrystalClk = ~extSlowCrystalClk; end
	initial begin #16; forever #(SLOW_RC_PER * 25) intSlowRcClk = ~intSlowRcClk; end

	// ----------------------------------------------------------------------
	// tasks and expectations
	// ----------------------------------------------------------------------
	function automatic logic [31:0] statusWord(op_mode_type m, logic s, logic f, logic r);
		return {26'h0, m, s, f, r};
	endfunction

	function automatic op_mode_type haltMode(int k);
		case (k)
			0: return MODE_SLEEP;
			1: return IDLE_SLOW_ONLY;
			2: return IDLE_FAST_ONLY;
			default: return IDLE_BOTH_OSC;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// single AHB-Lite transfer; unused upper data bits carry random noise
	task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		r = $random(seed);
		@(posedge clock);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {r[23:0], d};
		do @(posedge clock); while (hready !== 1'b1);
		q = hrdata;
		chk(hresp, 1'b0);
		// registered outputs follow one edge after the data phase
		@(posedge clock);
		#1;
	endtask

	// second interval taken, the first may straddle a selection change
	task automatic measure(output int cnt);
		repeat (2) begin
			cnt = 0;
			do @(posedge clock); while (sysClkTick !== 1'b1);
			do begin @(posedge clock); cnt++; end while (sysClkTick !== 1'b1);
		end
	endtask

	task automatic pulse(input logic h);
		@(posedge clock);
		if (h) haltReq <= 1'b1;
		else wakeReq <= 1'b1;
		@(posedge clock);
		haltReq <= 1'b0;
		wakeReq <= 1'b0;
		#1;
	endtask

	task automatic end_of_test();
		if (fail_count == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ----------------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clock);
		rstn <= 1'b1;
		ahb(0, `SYS_CTRL_OFS, 8'h00); chk(q, `SYS_CTRL_RST);
		ahb(0, `FAST_RC_CTRL_OFS, 8'h00); chk(q, `FAST_RC_CTRL_RST);
		ahb(0, `SLOW_XTAL_CTRL_OFS, 8'h00); chk(q, `SLOW_XTAL_CTRL_RST);
		ahb(0, `MODE_STAT_OFS, 8'h00); chk(q, statusWord(MODE_FAST, 1, 1, 1));
		ahb(0, 8'h14, 8'h00); chk(q, 32'h0);
		chk(slowXtalPinsFree, 1'b1);
		for (int i = 0; i < 4; i++) begin
			ahb(1, `FAST_RC_CTRL_OFS, {4'h0, 2'(i), 2'h1});
			chk(fastRcFreqCode, (i == 3) ? 2'h0 : 2'(i));
		end
		ahb(1, `FAST_RC_CTRL_OFS, 8'h01);
		for (int s = 0; s < 7; s++) begin
			ahb(1, `SYS_CTRL_OFS, {3'(s), 5'h00});
			measure(n);
			chk(n, FAST_RC_PER << s);
		end
		ahb(1, `SYS_CTRL_OFS, 8'h08);
		chk({extFastCrystalRun, intFastRcRun}, 2'h2);
		measure(n);
		chk(n, EXT_FAST_PER);
		ahb(1, `SYS_CTRL_OFS, 8'h00);
		ahb(1, `SLOW_XTAL_CTRL_OFS, 8'h05);
		chk({slowXtalSpeedupOut, slowXtalReady, slowXtalPinsFree, extSlowCrystalRun}, 4'h9);
		for (n = 0; n < 400 && slowXtalReady !== 1'b1; n++) @(posedge clock);
		chk(slowXtalReady, 1'b1);
		ahb(1, `SLOW_XTAL_CTRL_OFS, 8'h01);
		chk({slowXtalSpeedupOut, slowXtalReady}, 2'h1);
		ahb(1, `SLOW_XTAL_CTRL_OFS, 8'h05);
		ahb(1, `SYS_CTRL_OFS, 8'hE4);
		ahb(1, `SLOW_XTAL_CTRL_OFS, 8'h01);
		chk(slowXtalSpeedupOut, 1'b1);
		ahb(0, `MODE_STAT_OFS, 8'h00); chk(q, statusWord(MODE_SLOW, 1, 1, 1));
		measure(n);
		chk(n, SLOW_XT_PER);
		ahb(1, `FAST_RC_CTRL_OFS, 8'h00);
		chk({fastClkOn, intFastRcRun}, 2'h0);
		ahb(1, `SYS_CTRL_OFS, 8'hE0);
		measure(n);
		chk(n, SLOW_RC_PER);
		ahb(1, `FAST_RC_CTRL_OFS, 8'h01);
		chk(intFastRcRun, 1'b1);
		// last pass is sleep again with the watchdog forced on
		for (int k = 0; k < 5; k++) begin
			ahb(1, `SYS_CTRL_OFS, {6'h00, 2'(k)});
			watchdogEn <= (k == 0) ? 1'b0 : (k == 4) ? 1'b1 : 1'($random(seed));
			pulse(1);
			chk({opMode, coreRun, fastClkOn, subClkOn}, {haltMode(k % 4), 1'b0, 2'(k)});
			chk(intSlowRcRun, !(k % 4 == 0 && watchdogEn == 1'b0));
			pulse(0);
			chk({opMode, coreRun}, {MODE_FAST, 1'b1});
		end
		end_of_test();
	end

	initial begin
		repeat (40000) @(posedge clock);
		fail_count++;
		end_of_test();
	end
endmodule
